// ---- hdl/nsl_pkg.sv ----
// Constants shared by the network strap and indicator block.
package nsl_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int HOLD_MS = 50;
    localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
    localparam int POL_PULSE_LIMIT = 7;
    localparam int POL_PACKET_LIMIT = 3;
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam int CFG_FORCE_TP = 0;
    localparam int ST_EXT_CODEC = 0;
    localparam int ST_AUI = 1;
    localparam int ST_LINK_CHECK = 2;
    localparam int ST_LOW_SQUELCH = 3;
    localparam int ST_LINK_GOOD = 4;
    localparam int ST_POL_REVERSED = 5;
    localparam int ST_TX_LED = 6;
    localparam int ST_RX_LED = 7;
    localparam int ST_COL_LED = 8;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_COL = 2;
    localparam int IRQ_POL = 3;
    localparam int IRQ_LINK = 4;
    localparam int IRQ_WIDTH = 5;
endpackage

// ---- hdl/nsl_hold_timer.sv ----
// Retriggerable hold timer that keeps an indicator active after each event.
`timescale 1ns/10ps
`default_nettype none
module nsl_hold_timer #(
    parameter int HOLD = 2000000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic trigger,
    output logic active
);
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
        if (trigger) begin
            next_count = 32'(HOLD);
        end else if (count != 32'h0000_0000) begin
            next_count = count - 32'h0000_0001;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0000_0000;
        end else begin
            count <= next_count;
        end
    end

    assign active = (count != 32'h0000_0000);
endmodule
`default_nettype wire

// ---- hdl/nsl_strap_led.sv ----
// Strap decode, activity indicators and APB status for the network side.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - External codec select high disables the internal Manchester codec, low enables it.
// - Dual-function carrier, collision and clock pins take function one when that strap is 0, two when 1.
// - Attachment select high routes the codec to AUI, low to the twisted-pair module.
// - Transmit indicator goes low for about 50 ms on each transmission.
// - Receive indicator goes low for about 50 ms on each receive detection.
// - Collision indicator goes low for about 50 ms on each collision.
// - Polarity indicator stays high until seven reversed link pulses or three reversed packets in a row.
// - Link indicator is high in AUI mode, or when link testing is on and the link is bad.
// - Link indicator is low in twisted-pair mode with a good link, or in twisted-pair mode whenever link testing is off.
// - Link disable strap at 0 stops link pulse generation and integrity checking.
// - Low squelch strap at 1 selects the reduced receive threshold.
module nsl_strap_led #(
    parameter int HOLD_CYCLES = nsl_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic externalCodecSelect,
    input wire logic attachmentPathSelect,
    input wire logic linkCheckDisable,
    input wire logic lowSquelchSelect,
    input wire logic txEvent,
    input wire logic rxEvent,
    input wire logic colEvent,
    input wire logic linkPulse,
    input wire logic linkPulseReversed,
    input wire logic rxPacketEnd,
    input wire logic rxPacketReversed,
    input wire logic linkIntegrityGood,
    input wire logic codecCarrier,
    input wire logic codecCollision,
    input wire logic codecRxData,
    input wire logic codecRxClock,
    input wire logic codecTxClock,
    input wire logic pinCarrierIn,
    input wire logic pinCollisionIn,
    input wire logic pinRxDataIn,
    input wire logic pinRxClockIn,
    input wire logic pinTxClockIn,
    output logic pinCarrierOut,
    output logic pinCollisionOut,
    output logic pinRxDataOut,
    output logic pinRxClockOut,
    output logic pinTxClockOut,
    output logic pinDualOe,
    output logic macCarrier,
    output logic macCollision,
    output logic macRxData,
    output logic macRxClock,
    output logic macTxClock,
    output logic internalCodecEnable,
    output logic auiPathEnable,
    output logic twistedPathEnable,
    output logic linkPulseGenEnable,
    output logic linkIntegrityEnable,
    output logic lowSquelchEnable,
    output logic transmitIndicator_n,
    output logic receiveIndicator_n,
    output logic collisionIndicator_n,
    output logic polarityIndicator_n,
    output logic linkGoodIndicator_n,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic rstMeta, rstSync;
    logic [3:0] strapMeta, strapSync;
    logic [4:0] dualMeta, dualSync;
    logic extCodec, aui, linkCheck, low_squelch_select;
    logic txHold, rxHold, colHold;
    logic [2:0] activityEvent, activityHold;
    logic [4:0] codecBus, macBus;
    logic [2:0] pulseRun, next_pulseRun;
    logic [1:0] packetRun, next_packetRun;
    logic polReversed, next_polReversed;
    logic linkOn;
    logic linkOnPrev, polPrev;
    logic next_linkOnPrev, next_polPrev;
    logic [nsl_pkg::IRQ_WIDTH-1:0] irqStatus, next_irqStatus, irqMask, next_irqMask, irqEvents;
    logic [31:0] next_prdata;
    logic [31:0] statusWord;
    logic access, wrAccess, mapped;

    // Reset is released synchronously so no flop leaves reset on a partial edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Straps and incoming dual-function pins are asynchronous to clk.
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            strapMeta <= 4'h0;
            strapSync <= 4'h0;
            dualMeta <= 5'h00;
            dualSync <= 5'h00;
        end else begin
            strapMeta <= {lowSquelchSelect, linkCheckDisable, attachmentPathSelect, externalCodecSelect};
            strapSync <= strapMeta;
            dualMeta <= {pinTxClockIn, pinRxClockIn, pinRxDataIn, pinCollisionIn, pinCarrierIn};
            dualSync <= dualMeta;
        end
    end

    assign extCodec = strapSync[0];
    assign aui = strapSync[1];
    assign linkCheck = strapSync[2];
    assign low_squelch_select = strapSync[3];

    assign internalCodecEnable = !extCodec;
    assign auiPathEnable = aui;
    assign twistedPathEnable = !aui;
    assign linkPulseGenEnable = linkCheck;
    assign linkIntegrityEnable = linkCheck;
    assign lowSquelchEnable = low_squelch_select;

    // Function one drives the internal codec out on the pins; function two takes an external codec in.
    assign pinDualOe = !extCodec;
    assign pinCarrierOut = codecCarrier;
    assign pinCollisionOut = codecCollision;
    assign pinRxDataOut = codecRxData;
    assign pinRxClockOut = codecRxClock;
    assign pinTxClockOut = codecTxClock;
    assign codecBus = {codecTxClock, codecRxClock, codecRxData, codecCollision, codecCarrier};
    // The pin side is the synchronised copy, so an external codec is seen two cycles behind its pins.
    for (genvar b = 0; b < 5; b++) begin : gen_dual
        assign macBus[b] = extCodec ? dualSync[b] : codecBus[b];
    end
    assign macCarrier = macBus[0];
    assign macCollision = macBus[1];
    assign macRxData = macBus[2];
    assign macRxClock = macBus[3];
    assign macTxClock = macBus[4];

    assign activityEvent = {colEvent, rxEvent, txEvent};
    // Every event reloads its timer, so a lamp stays lit for as long as traffic keeps coming.
    for (genvar g = 0; g < 3; g++) begin : gen_hold
        nsl_hold_timer #(.HOLD(HOLD_CYCLES)) nsl_hold_timer_i (
            .clk(clk),
            .rstn(rstSync),
            .trigger(activityEvent[g]),
            .active(activityHold[g])
        );
    end
    assign txHold = activityHold[0];
    assign rxHold = activityHold[1];
    assign colHold = activityHold[2];
    assign transmitIndicator_n = !txHold;
    assign receiveIndicator_n = !rxHold;
    assign collisionIndicator_n = !colHold;

    // A correctly polarised pulse or packet breaks the run and clears the flag.
    // A run stops counting at its limit, so the flag holds while reversed traffic continues.
    always_comb begin
        next_pulseRun = pulseRun;
        next_packetRun = packetRun;
        next_polReversed = polReversed;
        if (aui) begin
            next_pulseRun = 3'h0;
            next_packetRun = 2'h0;
            next_polReversed = 1'b0;
        end else begin
            if (linkPulse) begin
                if (!linkPulseReversed) begin
                    next_pulseRun = 3'h0;
                    next_polReversed = 1'b0;
                end else if (32'(pulseRun) + 1 >= nsl_pkg::POL_PULSE_LIMIT) begin
                    next_polReversed = 1'b1;
                end else begin
                    next_pulseRun = pulseRun + 3'h1;
                end
            end
            if (rxPacketEnd) begin
                if (!rxPacketReversed) begin
                    next_packetRun = 2'h0;
                    next_polReversed = 1'b0;
                end else if (32'(packetRun) + 1 >= nsl_pkg::POL_PACKET_LIMIT) begin
                    next_polReversed = 1'b1;
                end else begin
                    next_packetRun = packetRun + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            pulseRun <= 3'h0;
            packetRun <= 2'h0;
            polReversed <= 1'b0;
        end else begin
            pulseRun <= next_pulseRun;
            packetRun <= next_packetRun;
            polReversed <= next_polReversed;
        end
    end
    assign polarityIndicator_n = !polReversed;

    assign linkOn = !aui && (!linkCheck || linkIntegrityGood);
    assign linkGoodIndicator_n = !linkOn;

    // Interrupt events: every transmit, receive and collision event, polarity change, link change.
    always_comb begin
        next_linkOnPrev = linkOn;
        next_polPrev = polReversed;
    end

    // The link history starts lit, as the decode shows with all straps low, so reset raises no false change.
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            linkOnPrev <= 1'b1;
            polPrev <= 1'b0;
        end else begin
            linkOnPrev <= next_linkOnPrev;
            polPrev <= next_polPrev;
        end
    end
    assign irqEvents = {linkOn ^ linkOnPrev, polReversed ^ polPrev, colEvent, rxEvent, txEvent};

    assign access = psel && penable;
    assign wrAccess = access && pwrite;
    assign mapped = (paddr == nsl_pkg::REG_CONFIG) || (paddr == nsl_pkg::REG_STATUS) ||
        (paddr == nsl_pkg::REG_IRQ_STATUS) || (paddr == nsl_pkg::REG_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // A new event wins over a write-one clear in the same cycle.
    always_comb begin
        next_irqStatus = irqStatus;
        next_irqMask = irqMask;
        if (wrAccess && paddr == nsl_pkg::REG_IRQ_STATUS) begin
            next_irqStatus = irqStatus & ~pwdata[nsl_pkg::IRQ_WIDTH-1:0];
        end
        if (wrAccess && paddr == nsl_pkg::REG_IRQ_MASK) begin
            next_irqMask = pwdata[nsl_pkg::IRQ_WIDTH-1:0];
        end
        next_irqStatus = next_irqStatus | irqEvents;
    end

    // Status is gathered into one word so the read select below stays a plain word choice.
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[nsl_pkg::ST_EXT_CODEC] = extCodec;
        statusWord[nsl_pkg::ST_AUI] = aui;
        statusWord[nsl_pkg::ST_LINK_CHECK] = linkCheck;
        statusWord[nsl_pkg::ST_LOW_SQUELCH] = low_squelch_select;
        statusWord[nsl_pkg::ST_LINK_GOOD] = linkOn;
        statusWord[nsl_pkg::ST_POL_REVERSED] = polReversed;
        statusWord[nsl_pkg::ST_TX_LED] = txHold;
        statusWord[nsl_pkg::ST_RX_LED] = rxHold;
        statusWord[nsl_pkg::ST_COL_LED] = colHold;
    end

    // Read data is captured in the setup cycle and held through the access phase.
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                nsl_pkg::REG_CONFIG: next_prdata = 32'h0000_0000;
                nsl_pkg::REG_STATUS: next_prdata = statusWord;
                nsl_pkg::REG_IRQ_STATUS: next_prdata[nsl_pkg::IRQ_WIDTH-1:0] = irqStatus;
                nsl_pkg::REG_IRQ_MASK: next_prdata[nsl_pkg::IRQ_WIDTH-1:0] = irqMask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end else if (access) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            irqStatus <= '0;
            irqMask <= '0;
        end else begin
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end
    assign irq = |(irqStatus & irqMask);
endmodule
`default_nettype wire

// ---- tb/nsl_strap_led_properties.sv ----
// Concurrent checks on strap decode, indicator holds and polarity detection.
`timescale 1ns/10ps
`default_nettype none
module nsl_strap_led_props #(
    parameter int HOLD_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic externalCodecSelect,
    input wire logic attachmentPathSelect,
    input wire logic linkCheckDisable,
    input wire logic lowSquelchSelect,
    input wire logic txEvent,
    input wire logic rxEvent,
    input wire logic colEvent,
    input wire logic linkPulse,
    input wire logic linkPulseReversed,
    input wire logic rxPacketEnd,
    input wire logic rxPacketReversed,
    input wire logic linkIntegrityGood,
    input wire logic pinDualOe,
    input wire logic internalCodecEnable,
    input wire logic auiPathEnable,
    input wire logic linkPulseGenEnable,
    input wire logic lowSquelchEnable,
    input wire logic transmitIndicator_n,
    input wire logic receiveIndicator_n,
    input wire logic collisionIndicator_n,
    input wire logic polarityIndicator_n,
    input wire logic linkGoodIndicator_n,
    input wire logic codecCarrier,
    input wire logic codecCollision,
    input wire logic codecRxData,
    input wire logic codecRxClock,
    input wire logic codecTxClock,
    input wire logic pinCarrierIn,
    input wire logic pinCollisionIn,
    input wire logic pinRxDataIn,
    input wire logic pinRxClockIn,
    input wire logic pinTxClockIn,
    input wire logic pinCarrierOut,
    input wire logic pinCollisionOut,
    input wire logic pinRxDataOut,
    input wire logic pinRxClockOut,
    input wire logic pinTxClockOut,
    input wire logic macCarrier,
    input wire logic macCollision,
    input wire logic macRxData,
    input wire logic macRxClock,
    input wire logic macTxClock
);
    logic [4:0] codecVec, pinInVec, pinOutVec, macVec;
    assign codecVec = {codecTxClock, codecRxClock, codecRxData, codecCollision, codecCarrier};
    assign pinInVec = {pinTxClockIn, pinRxClockIn, pinRxDataIn, pinCollisionIn, pinCarrierIn};
    assign pinOutVec = {pinTxClockOut, pinRxClockOut, pinRxDataOut, pinCollisionOut, pinCarrierOut};
    assign macVec = {macTxClock, macRxClock, macRxData, macCollision, macCarrier};
    logic [31:0] txAge, next_txAge;
    logic [2:0] pulseRun, next_pulseRun, pktRun, next_pktRun;
    logic clearRuns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // A strap is trusted only after it outlasts the reset release and the synchroniser.
    sequence settled(s);
        $stable(s) [*6];
    endsequence
    always_comb begin
        clearRuns = auiPathEnable || (linkPulse && !linkPulseReversed) || (rxPacketEnd && !rxPacketReversed);
        next_pulseRun = clearRuns ? 3'h0 : pulseRun + 3'(linkPulse && pulseRun != 3'h7);
        next_pktRun = clearRuns ? 3'h0 : pktRun + 3'(rxPacketEnd && pktRun != 3'h7);
        next_txAge = txEvent ? 32'h1 : ((txAge != 0 && txAge <= HOLD_CYCLES) ? txAge + 1 : 32'h0);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txAge <= 32'h0;
            pulseRun <= 3'h0;
            pktRun <= 3'h0;
        end else begin
            txAge <= next_txAge;
            pulseRun <= next_pulseRun;
            pktRun <= next_pktRun;
        end
    end
    tx_hold_a: assert property (txAge != 0 |-> transmitIndicator_n == (txAge > HOLD_CYCLES))
        else $error("transmit hold length wrong");
    rx_hold_a: assert property (rxEvent |=> !receiveIndicator_n [*8])
        else $error("receive indicator not held");
    col_start_a: assert property (colEvent |-> ##1 (!collisionIndicator_n [*2]))
        else $error("collision indicator not held");
    pol_pulse_a: assert property (linkPulse && linkPulseReversed && pulseRun == 3'h6 && !auiPathEnable
        && !rxPacketEnd |=> !polarityIndicator_n) else $error("seventh reversed pulse missed");
    pol_packet_a: assert property (rxPacketEnd && rxPacketReversed && pktRun == 3'h2 && !auiPathEnable
        && !linkPulse |=> !polarityIndicator_n) else $error("third reversed packet missed");
    pol_clear_a: assert property (linkPulse && !linkPulseReversed && !rxPacketEnd |=> polarityIndicator_n)
        else $error("polarity not cleared");
    link_off_a: assert property (auiPathEnable || (linkPulseGenEnable && !linkIntegrityGood) |-> linkGoodIndicator_n)
        else $error("link indicator on wrongly");
    link_on_a: assert property (!auiPathEnable && (!linkPulseGenEnable || linkIntegrityGood) |-> !linkGoodIndicator_n)
        else $error("link indicator off wrongly");
    dual_pin_a: assert property (pinDualOe == internalCodecEnable)
        else $error("dual pin drive mismatch");
    pin_copy_a: assert property (pinOutVec == codecVec)
        else $error("dual pin outputs differ from codec");
    mac_internal_a: assert property (internalCodecEnable |-> macVec == codecVec)
        else $error("internal codec path not selected");
    mac_external_a: assert property (!internalCodecEnable |-> macVec == $past(pinInVec, 2))
        else $error("external codec path not selected");
    codec_sel_a: assert property (settled(externalCodecSelect) |-> internalCodecEnable != externalCodecSelect)
        else $error("codec select wrong");
    path_sel_a: assert property (settled(attachmentPathSelect) |-> auiPathEnable == attachmentPathSelect)
        else $error("path select wrong");
    link_test_a: assert property (settled(linkCheckDisable) |-> linkPulseGenEnable == linkCheckDisable)
        else $error("link test enable wrong");
    squelch_sel_a: assert property (settled(lowSquelchSelect) |-> lowSquelchEnable == lowSquelchSelect)
        else $error("squelch select wrong");
endmodule
bind nsl_strap_led nsl_strap_led_props #(.HOLD_CYCLES(HOLD_CYCLES)) nsl_strap_led_props_i (.*);
`default_nettype wire

// ---- tb/nsl_far_model.sv ----
// External codec standing on the dual-function pins.
`timescale 1ns/10ps
`default_nettype none
module nsl_far_model (
    input wire logic clk,
    input wire logic pinDualOe,
    output logic [4:0] pinIn
);
    // While the device drives the pins this side is released, so the lines toggle and carry no value.
    initial pinIn = 5'h00;
    always @(posedge clk)
        pinIn <= pinDualOe ? ~pinIn : 5'($urandom);
endmodule
`default_nettype wire

// ---- tb/nsl_strap_led_test.sv ----
// Self-checking bench for the network strap and indicator block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module nsl_strap_led_test;
    localparam int HOLD = 20;
    typedef struct {logic [32:0] exp; logic [32:0] msk; bit bus;} nsl_note_t;
    logic clk = 0, rstn = 0, txEvent = 0, rxEvent = 0, colEvent = 0, linkPulse = 0, linkPulseReversed = 0;
    logic rxPacketEnd = 0, rxPacketReversed = 0, linkIntegrityGood = 0, psel = 0, penable = 0, pwrite = 0;
    logic externalCodecSelect = 0, attachmentPathSelect = 0, linkCheckDisable = 0, lowSquelchSelect = 0;
    logic codecCarrier = 0, codecCollision = 0, codecRxData = 0, codecRxClock = 0, codecTxClock = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, gotRd;
    wire logic pinCarrierIn, pinCollisionIn, pinRxDataIn, pinRxClockIn, pinTxClockIn;
    logic pinCarrierOut, pinCollisionOut, pinRxDataOut, pinRxClockOut, pinTxClockOut, pinDualOe, macCarrier;
    logic macCollision, macRxData, macRxClock, macTxClock, internalCodecEnable, auiPathEnable, twistedPathEnable;
    logic linkPulseGenEnable, linkIntegrityEnable, lowSquelchEnable, transmitIndicator_n, receiveIndicator_n;
    logic collisionIndicator_n, polarityIndicator_n, linkGoodIndicator_n, irq, pready, pslverr, gotErr;
    int bad_count = 0, checks = 0;
    nsl_note_t notes[$];
    event look;
    wire logic [12:0] obs = {internalCodecEnable, auiPathEnable, twistedPathEnable, linkPulseGenEnable,
        linkIntegrityEnable, lowSquelchEnable, pinDualOe, transmitIndicator_n, receiveIndicator_n,
        collisionIndicator_n, polarityIndicator_n, linkGoodIndicator_n, irq};
    nsl_strap_led #(.HOLD_CYCLES(HOLD)) nsl_strap_led_i (.*);
    nsl_far_model nsl_far_model_i (.clk(clk), .pinDualOe(pinDualOe),
        .pinIn({pinTxClockIn, pinRxClockIn, pinRxDataIn, pinCollisionIn, pinCarrierIn}));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) {codecCarrier, codecCollision, codecRxData, codecRxClock, codecTxClock} <= 5'($urandom);
    always @(look)
        while (notes.size() > 0) begin
            nsl_note_t n;
            n = notes.pop_front();
            `CHK((n.bus ? {gotErr, gotRd} : 33'(obs)) & n.msk, n.exp & n.msk)
        end
    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic note(input logic [32:0] e, input logic [32:0] m, input bit b);
        notes.push_back('{e, m, b});
        -> look;
    endtask
    task automatic see(input logic [12:0] e, input logic [12:0] m);
        note(33'(e), 33'(m), 1'b0);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            bad_count++;
            report_and_stop();
        end else begin
            gotRd = prdata;
            gotErr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        apb(1'b0, a, 32'h0);
        note(e, m, 1'b1);
    endtask
    task automatic fire(input int k);
        @(posedge clk) {colEvent, rxEvent, txEvent} <= 3'(1 << k);
        @(posedge clk) {colEvent, rxEvent, txEvent} <= 3'h0;
    endtask
    task automatic pol(input bit pkt, input bit rev);
        @(posedge clk);
        if (pkt) {rxPacketEnd, rxPacketReversed} <= {1'b1, rev};
        else {linkPulse, linkPulseReversed} <= {1'b1, rev};
        @(posedge clk) {rxPacketEnd, linkPulse} <= 2'b00;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(69));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) {lowSquelchSelect, linkCheckDisable, attachmentPathSelect, externalCodecSelect} <= i[3:0];
            linkIntegrityGood <= 1'($urandom);
            repeat (6) @(posedge clk);
            #1 see({!i[0], i[1], !i[1], i[2], i[2], i[3], !i[0], 4'h0, i[1] | (i[2] & !linkIntegrityGood), 1'b0},
                13'h1FC2);
        end
        @(posedge clk) {lowSquelchSelect, linkCheckDisable, attachmentPathSelect, externalCodecSelect} <= 4'h4;
        repeat (6) @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            fire(k);
            #1 see(13'h0, 13'(32 >> k));
            repeat (HOLD - 1) @(posedge clk);
            #1 see(13'h0, 13'(32 >> k));
            @(posedge clk) #1 see(13'(32 >> k), 13'(32 >> k));
        end
        // A second event part-way through must push the end of the hold out.
        fire(0);
        repeat (9) @(posedge clk);
        fire(0);
        repeat (HOLD - 5) @(posedge clk);
        #1 see(13'h0, 13'h20);
        repeat (5) @(posedge clk);
        #1 see(13'h20, 13'h20);
        for (int r = 0; r < 2; r++) begin
            pol(r, 0);
            repeat (6 - 4 * r) pol(r, 1);
            #1 see(13'h4, 13'h4);
            pol(r, 1);
            #1 see(13'h0, 13'h4);
            pol(r, 0);
            #1 see(13'h4, 13'h4);
        end
        rd(8'h04, 33'h4, 33'h1_0000_000F);
        rd(8'h00, 33'h0, 33'h1_FFFF_FFFF);
        rd(8'h10, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b1, 8'h08, 32'h1F);
        #1 see(13'h0, 13'h1);
        fire(0);
        repeat (2) @(posedge clk);
        #1 see(13'h1, 13'h1);
        rd(8'h08, 33'h1, 33'h1_0000_0001);
        apb(1'b1, 8'h08, 32'h1);
        #1 see(13'h0, 13'h1);
        apb(1'b1, 8'h0C, 32'h0);
        fire(0);
        repeat (2) @(posedge clk);
        #1 see(13'h0, 13'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
